// ===== inc/ftc_cfg.svh
// register map, field layout, command codes and timing counts of the frequency/totalize counter
`ifndef FTC_CFG_SVH
`define FTC_CFG_SVH

`define FTC_ADDR_CMD       8'h00
`define FTC_ADDR_CHLIST    8'h04
`define FTC_ADDR_STATUS    8'h08
`define FTC_ADDR_EVENTS    8'h0c
`define FTC_ADDR_MASK      8'h10
`define FTC_ADDR_READING   8'h14
`define FTC_ADDR_TOTAL     8'h18
`define FTC_ADDR_RELAY     8'h1c

`define FTC_CMD_FREQ       4'h1
`define FTC_CMD_TOTAL      4'h2
`define FTC_CMD_OPEN       4'h3
`define FTC_CMD_TRIGGER    4'h4
`define FTC_CMD_GATE_SHORT 4'h5
`define FTC_CMD_GATE_MID   4'h6
`define FTC_CMD_GATE_LONG  4'h7

`define FTC_CMD_CODE_LSB   0
`define FTC_CMD_CHAN_LSB   8
`define FTC_CMD_CHAN_GIVEN 13

`define FTC_FUNC_NONE      4'h0
`define FTC_FUNC_FREQ      4'h7

`define FTC_EV_DONE        0
`define FTC_EV_CHAN_ERR    1
`define FTC_EV_REFUSED     2
`define FTC_EV_SATURATED   3

`define FTC_NUM_CHAN       30
`define FTC_CHAN_PER_SLOT  10
`define FTC_STORE_DEPTH    32

`define FTC_TOTAL_MAX      16'hffff
`define FTC_CYCLE_MAX      20'hfffff

`define FTC_CLK_HZ         100000000
`define FTC_GATE_SHORT_US  100000
`define FTC_GATE_TICK_CYCLES (`FTC_CLK_HZ / 1000000 * `FTC_GATE_SHORT_US)
`define FTC_TICKS_SHORT    7'h01
`define FTC_TICKS_MID      7'h0a
`define FTC_TICKS_LONG     7'h64
`define FTC_SCALE_SHORT    7'h64
`define FTC_SCALE_MID      7'h0a
`define FTC_SCALE_LONG     7'h01

`endif

// ===== inc/ftc_pkg.sv
// types of the frequency/totalize counter
package ftc_pkg;
   typedef enum logic [1:0] {GATE_SHORT, GATE_MID, GATE_LONG} ftc_gate_t;
   typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_MEAS, ST_TOTAL} ftc_state_t;
endpackage : ftc_pkg

// ===== rtl/ftc_counter.sv
// frequency and totalize counter with apb register access
// Notes on behaviour
// - frequency equals complete input cycles counted within gate divided by gate length
// - three gate periods 0.1 s, 1 s, 10 s, each with own command code
// - five-digit resolution 10 Hz, 1 Hz, 0.1 Hz for short, middle, long gate
// - frequency range reaches 10 kHz; totalize holds counts up to 65535
// - frequency command sets frequency function code and middle gate
// - with channel list, measure each listed channel, store readings, return in order
// - without channel list, leave relays unchanged and take exactly one measurement
// - block other measurements while counting; accept them again once counting completes
// - totalize command clears event counter then counts each input pulse
// - totalize runs indefinitely until another accepted measurement command arrives; gate commands leave it running
// - bus trigger during totalize aborts it and takes a frequency measurement
// - reading running count during totalize neither clears nor stops it
// - at most one totalize channel; error if not a multiplexer channel; code closes the new relay and leaves earlier ones closed
// - totalize channel stays closed until a later command opens it
// - after reset the gate period is one second
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ftc_cfg.svh"

module ftc_counter #(
   parameter int unsigned GATE_TICK_CYCLES = `FTC_GATE_TICK_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sig_in,
   input  wire logic [2:0]  mux_slot_present,
   output logic [29:0]      relay_close,
   output logic             counter_busy,
   output logic             irq
);
   import ftc_pkg::*;

   ftc_state_t  state;
   ftc_gate_t   gate_sel, gate_cur;
   logic [3:0]  func_code, events, mask;
   logic [29:0] chlist, chlist_run;
   logic [4:0]  scan_idx, wr_ptr, rd_ptr;
   logic [31:0] pre_cnt;
   logic [6:0]  tick_cnt;
   logic [19:0] edge_cnt;
   logic [15:0] total_cnt;
   logic [23:0] store_mem [`FTC_STORE_DEPTH];
   logic [5:0]  store_cnt;
   logic        sig_s1, sig_s2, sig_s3, scanning;
   logic [2:0]  slot_s1, slot_s2;

   logic        acc, cmd_wr, cmd_given, cmd_is_meas, busy_meas, refused, accepted, chan_ok;
   logic        sig_rise, gate_tick, gate_end, push, pop, tot_start, tot_sat, meas_start;
   logic [3:0]  cmd_code, ev_set;
   logic [4:0]  cmd_chan;
   logic [6:0]  gate_ticks, gate_scale;
   logic [19:0] cycles;
   logic [23:0] reading;

   // pin inputs cross into pclk through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_s1  <= 1'b0;
         sig_s2  <= 1'b0;
         sig_s3  <= 1'b0;
         slot_s1 <= 3'h0;
         slot_s2 <= 3'h0;
      end else begin
         sig_s1  <= sig_in;
         sig_s2  <= sig_s1;
         sig_s3  <= sig_s2;
         slot_s1 <= mux_slot_present;
         slot_s2 <= slot_s1;
      end
   end

   assign sig_rise = sig_s2 & ~sig_s3;

   // command decode
   assign acc         = psel & penable & pready;
   assign cmd_wr      = acc & pwrite & (paddr == `FTC_ADDR_CMD);
   assign cmd_code    = pwdata[`FTC_CMD_CODE_LSB +: 4];
   assign cmd_chan    = pwdata[`FTC_CMD_CHAN_LSB +: 5];
   assign cmd_given   = pwdata[`FTC_CMD_CHAN_GIVEN];
   assign cmd_is_meas = (cmd_code == `FTC_CMD_FREQ) || (cmd_code == `FTC_CMD_TOTAL) ||
                        (cmd_code == `FTC_CMD_OPEN) || (cmd_code == `FTC_CMD_TRIGGER);
   assign busy_meas   = (state == ST_SCAN) || (state == ST_MEAS);
   assign refused     = cmd_wr & cmd_is_meas & busy_meas;
   assign accepted    = cmd_wr & cmd_is_meas & ~busy_meas;

   // only multiplexer slots with a board fitted accept a totalize channel
   always_comb begin
      chan_ok = 1'b0;
      if (cmd_chan >= 5'd20) begin
         chan_ok = (cmd_chan < 5'd30) & slot_s2[2];
      end else if (cmd_chan >= 5'd10) begin
         chan_ok = slot_s2[1];
      end else begin
         chan_ok = slot_s2[0];
      end
   end

   assign tot_start  = accepted & (cmd_code == `FTC_CMD_TOTAL) & (~cmd_given | chan_ok);

   // gate length and scale to 0.1 Hz units, fixed for the whole measurement
   always_comb begin
      case (gate_cur)
         GATE_SHORT: begin
            gate_ticks = `FTC_TICKS_SHORT;
            gate_scale = `FTC_SCALE_SHORT;
         end
         GATE_LONG: begin
            gate_ticks = `FTC_TICKS_LONG;
            gate_scale = `FTC_SCALE_LONG;
         end
         default: begin
            gate_ticks = `FTC_TICKS_MID;
            gate_scale = `FTC_SCALE_MID;
         end
      endcase
   end

   assign gate_tick = (pre_cnt == GATE_TICK_CYCLES - 1);
   assign gate_end  = (state == ST_MEAS) & gate_tick & (tick_cnt == gate_ticks - 7'h01);
   // first edge opens the count, so n edges span n-1 whole cycles
   assign cycles    = (edge_cnt == 20'h0) ? 20'h0 : edge_cnt - 20'h1;
   assign reading   = 24'(cycles * gate_scale);
   assign push      = gate_end & (store_cnt != 6'(`FTC_STORE_DEPTH));
   assign tot_sat   = (state == ST_TOTAL) & sig_rise & (total_cnt == `FTC_TOTAL_MAX);

   always_comb begin
      meas_start = 1'b0;
      if (accepted && (cmd_code == `FTC_CMD_TRIGGER)) begin
         meas_start = 1'b1;
      end else if (accepted && (cmd_code == `FTC_CMD_FREQ) && (chlist == 30'h0)) begin
         meas_start = 1'b1;
      end else if ((state == ST_SCAN) && (scan_idx < 5'd30) && chlist_run[scan_idx]) begin
         meas_start = 1'b1;
      end
   end

   // measurement sequencer, channel relays and function selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state       <= ST_IDLE;
         gate_sel    <= GATE_MID;
         gate_cur    <= GATE_MID;
         func_code   <= `FTC_FUNC_NONE;
         chlist_run  <= 30'h0;
         scan_idx    <= 5'h0;
         scanning    <= 1'b0;
         relay_close <= 30'h0;
      end else begin
         if (cmd_wr && (cmd_code == `FTC_CMD_GATE_SHORT)) begin
            gate_sel <= GATE_SHORT;
         end else if (cmd_wr && (cmd_code == `FTC_CMD_GATE_MID)) begin
            gate_sel <= GATE_MID;
         end else if (cmd_wr && (cmd_code == `FTC_CMD_GATE_LONG)) begin
            gate_sel <= GATE_LONG;
         end
         if (accepted) begin
            // any accepted measurement command ends totalize; gate commands do not
            state <= ST_IDLE;
            case (cmd_code)
               `FTC_CMD_FREQ: begin
                  func_code <= `FTC_FUNC_FREQ;
                  gate_sel  <= GATE_MID;
                  gate_cur  <= GATE_MID;
                  if (chlist != 30'h0) begin
                     chlist_run <= chlist;
                     scan_idx   <= 5'h0;
                     state      <= ST_SCAN;
                  end else begin
                     scanning <= 1'b0;
                     state    <= ST_MEAS;
                  end
               end
               `FTC_CMD_TRIGGER: begin
                  func_code <= `FTC_FUNC_FREQ;
                  gate_cur  <= gate_sel;
                  scanning  <= 1'b0;
                  state     <= ST_MEAS;
               end
               `FTC_CMD_TOTAL: begin
                  if (tot_start) begin
                     state <= ST_TOTAL;
                     if (cmd_given) begin
                        relay_close[cmd_chan] <= 1'b1;
                     end
                  end
               end
               default: begin
                  relay_close <= 30'h0;
               end
            endcase
         end else begin
            case (state)
               ST_SCAN: begin
                  if (scan_idx >= 5'd30) begin
                     state <= ST_IDLE;
                  end else if (chlist_run[scan_idx]) begin
                     relay_close <= 30'h1 << scan_idx;
                     gate_cur    <= gate_sel;
                     scanning    <= 1'b1;
                     state       <= ST_MEAS;
                  end else begin
                     scan_idx <= scan_idx + 5'h1;
                  end
               end
               ST_MEAS: begin
                  if (gate_end) begin
                     if (scanning) begin
                        scan_idx <= scan_idx + 5'h1;
                        state    <= ST_SCAN;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // gate timebase and input cycle counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt  <= 32'h0;
         tick_cnt <= 7'h0;
         edge_cnt <= 20'h0;
      end else if (meas_start) begin
         pre_cnt  <= 32'h0;
         tick_cnt <= 7'h0;
         edge_cnt <= 20'h0;
      end else if (state == ST_MEAS) begin
         pre_cnt <= gate_tick ? 32'h0 : pre_cnt + 32'h1;
         if (gate_tick) begin
            tick_cnt <= tick_cnt + 7'h1;
         end
         if (sig_rise && (edge_cnt != `FTC_CYCLE_MAX)) begin
            edge_cnt <= edge_cnt + 20'h1;
         end
      end
   end

   // totalize event counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         total_cnt <= 16'h0;
      end else if (tot_start) begin
         total_cnt <= 16'h0;
      end else if ((state == ST_TOTAL) && sig_rise && (total_cnt != `FTC_TOTAL_MAX)) begin
         total_cnt <= total_cnt + 16'h1;
      end
   end

   // reading store, drained oldest first; a full store drops new readings
   assign pop = acc & ~pwrite & (paddr == `FTC_ADDR_READING) & (store_cnt != 6'h0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr    <= 5'h0;
         rd_ptr    <= 5'h0;
         store_cnt <= 6'h0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 5'h1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 5'h1;
         end
         if (push && !pop) begin
            store_cnt <= store_cnt + 6'h1;
         end else if (pop && !push) begin
            store_cnt <= store_cnt - 6'h1;
         end
      end
   end

   always_ff @(posedge pclk) begin
      if (push) begin
         store_mem[wr_ptr] <= reading;
      end
   end

   // sticky events; a new event wins over a write-one clear
   always_comb begin
      ev_set = 4'h0;
      ev_set[`FTC_EV_DONE]      = gate_end & ~scanning | (state == ST_SCAN) & (scan_idx >= 5'd30);
      ev_set[`FTC_EV_CHAN_ERR]  = accepted & (cmd_code == `FTC_CMD_TOTAL) & cmd_given & ~chan_ok;
      ev_set[`FTC_EV_REFUSED]   = refused | gate_end & ~push;
      ev_set[`FTC_EV_SATURATED] = tot_sat;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         events <= 4'h0;
      end else if (acc && pwrite && (paddr == `FTC_ADDR_EVENTS)) begin
         events <= (events & ~pwdata[3:0]) | ev_set;
      end else begin
         events <= events | ev_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask   <= 4'h0;
         chlist <= 30'h0;
      end else if (acc && pwrite && (paddr == `FTC_ADDR_MASK)) begin
         mask <= pwdata[3:0];
      end else if (acc && pwrite && (paddr == `FTC_ADDR_CHLIST)) begin
         chlist <= pwdata[29:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq          <= 1'b0;
         counter_busy <= 1'b0;
      end else begin
         irq          <= |(events & mask);
         counter_busy <= (state != ST_IDLE);
      end
   end

   // apb slave: one wait-free access phase, data sampled in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         if (psel && !penable) begin
            if (paddr == `FTC_ADDR_CMD) begin
               prdata <= 32'h0;
            end else if (paddr == `FTC_ADDR_CHLIST) begin
               prdata <= {2'h0, chlist};
            end else if (paddr == `FTC_ADDR_STATUS) begin
               prdata <= {16'h0, store_cnt, gate_sel, func_code, 1'b0, state};
            end else if (paddr == `FTC_ADDR_EVENTS) begin
               prdata <= {28'h0, events};
            end else if (paddr == `FTC_ADDR_MASK) begin
               prdata <= {28'h0, mask};
            end else if (paddr == `FTC_ADDR_READING) begin
               prdata <= {(store_cnt != 6'h0), 7'h0, store_mem[rd_ptr]};
            end else if (paddr == `FTC_ADDR_TOTAL) begin
               prdata <= {16'h0, total_cnt};
            end else if (paddr == `FTC_ADDR_RELAY) begin
               prdata <= {2'h0, relay_close};
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end

endmodule : ftc_counter
`default_nettype wire

// ===== dv/ftc_counter_monitor.sv
// checker of the counter's bus answers, status fields, busy and interrupt outputs
`timescale 1ns/1ps
`default_nettype none
`include "ftc_cfg.svh"
module ftc_counter_monitor #(
   parameter int unsigned GATE_TICK_CYCLES = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        counter_busy,
   input wire logic        irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence rd_setup_s(a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   sequence wr_done_s(a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   ready_after_setup_a: assert property (setup_s |=> pready)
      else $error("no ready in first access cycle");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside an access cycle");
   unmapped_error_a: assert property (setup_s ##0 paddr > 8'h1c |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (setup_s ##0 (paddr <= 8'h1c && paddr[1:0] == 2'h0) |=> !pslverr)
      else $error("mapped access refused");
   cmd_reads_zero_a: assert property (rd_setup_s(`FTC_ADDR_CMD) |=> prdata == 32'h0)
      else $error("command register read not zero");
   status_fields_a: assert property (
      rd_setup_s(`FTC_ADDR_STATUS) |=> prdata[7:4] inside {4'h0, 4'h7} && prdata[9:8] != 2'h3)
      else $error("status function or gate field illegal");
   busy_start_a: assert property (
      wr_done_s(`FTC_ADDR_CMD) ##0 (pwdata[3:0] == `FTC_CMD_FREQ && !counter_busy) |-> ##[1:3] counter_busy)
      else $error("busy not raised by frequency command");
   irq_masked_a: assert property (wr_done_s(`FTC_ADDR_MASK) ##0 pwdata[3:0] == 4'h0 |-> ##2 !irq)
      else $error("interrupt high with all sources masked");
endmodule : ftc_counter_monitor
bind ftc_counter ftc_counter_monitor #(.GATE_TICK_CYCLES(GATE_TICK_CYCLES)) u_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .counter_busy(counter_busy), .irq(irq));
`default_nettype wire

// ===== dv/ftc_pulse_src.sv
// periodic pulse source standing in front of the counter input pin
`timescale 1ns/1ps
`default_nettype none
module ftc_pulse_src (
   input  wire logic       pclk,
   input  wire logic       run,
   input  wire logic [7:0] half,
   output logic            sig
);
   logic [7:0] cnt = 8'h00;
   logic       level = 1'b0;
   assign sig = level;
   // line rests low when stopped, so no stray rising edge is counted
   always @(posedge pclk) begin
      if (!run) begin
         cnt   <= 8'h00;
         level <= 1'b0;
      end else if (cnt == half - 8'h01) begin
         cnt   <= 8'h00;
         level <= !level;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule : ftc_pulse_src
`default_nettype wire

// ===== dv/ftc_counter_tb_top.sv
// self-checking bench of the frequency/totalize counter
`timescale 1ns/1ps
`default_nettype none
`include "ftc_cfg.svh"
module ftc_counter_tb_top;
   typedef struct {logic [31:0] val; logic [31:0] mask; logic err;} ftc_note_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [2:0]  mux_slot_present = 3'h3;
   logic        src_run = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, sig_in, counter_busy, irq;
   logic [29:0] relay_close;
   logic [31:0] lfsr = 32'hbda00c94;
   logic [31:0] k;
   logic [3:0]  gate_code [3] = '{`FTC_CMD_GATE_SHORT, `FTC_CMD_GATE_MID, `FTC_CMD_GATE_LONG};
   logic [31:0] gate_read [3] = '{32'h64, 32'hbe, 32'hc7};
   int          fail_count = 0;
   int          checks_done = 0;
   ftc_note_t   notes[$];
   ftc_note_t   got;
   always #5 pclk = ~pclk;
   ftc_counter #(.GATE_TICK_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sig_in(sig_in), .mux_slot_present(mux_slot_present), .relay_close(relay_close),
      .counter_busy(counter_busy), .irq(irq));
   ftc_pulse_src u_src (.pclk(pclk), .run(src_run), .half(8'h05), .sig(sig_in));
   function automatic logic [31:0] cmd(input logic [3:0] c, input logic [4:0] ch, input logic g);
      return {18'h0, g, ch, 4'h0, c};
   endfunction : cmd
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic conclude();
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e);
      int        n;
      ftc_note_t nt;
      nt.val = d;
      nt.mask = m;
      nt.err = e;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      if (!w) notes.push_back(nt);
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0, 1'b0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e = 1'b0);
      xfer(1'b0, a, d, m, e);
   endtask : rd
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 2500) begin
         @(posedge pclk);
         n++;
      end
      chk("done interrupt", 32'h1, {31'h0, irq});
   endtask : wait_irq
   // read results are judged here, against the oldest note left by the driver
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && notes.size() > 0) begin
         got = notes.pop_front();
         chk($sformatf("read data at %h", paddr), got.val & got.mask, prdata & got.mask);
         chk($sformatf("slave error at %h", paddr), {31'h0, got.err}, {31'h0, pslverr});
      end
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      conclude();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`FTC_ADDR_STATUS, 32'h100, 32'hffff);
      rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
      rd(`FTC_ADDR_CMD, 32'h0, 32'hffffffff);
      wr(`FTC_ADDR_MASK, 32'h1);
      rd(`FTC_ADDR_MASK, 32'h1, 32'hf);
      src_run <= 1'b1;
      wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_FREQ, 5'h0, 1'b0));
      wait_irq();
      chk("relays", 32'h0, {2'h0, relay_close});
      rd(`FTC_ADDR_READING, 32'h800000be, 32'h80ffffff);
      rd(`FTC_ADDR_STATUS, 32'h170, 32'hffff);
      wr(`FTC_ADDR_EVENTS, 32'hf);
      repeat (2) @(posedge pclk);
      chk("irq after clear", 32'h0, {31'h0, irq});
      for (int i = 0; i < 3; i++) begin
         wr(`FTC_ADDR_CMD, cmd(gate_code[i], 5'h0, 1'b0));
         wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_TRIGGER, 5'h0, 1'b0));
         if (i == 2) begin
            // gate change and a refused totalize command while the long gate is open
            wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_GATE_SHORT, 5'h0, 1'b0));
            wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_TOTAL, 5'h0, 1'b0));
            rd(`FTC_ADDR_EVENTS, 32'h4, 32'h4);
            rd(`FTC_ADDR_STATUS, 32'h2, 32'h7);
            chk("busy", 32'h1, {31'h0, counter_busy});
         end
         wait_irq();
         rd(`FTC_ADDR_READING, 32'h80000000 | gate_read[i], 32'h80ffffff);
         wr(`FTC_ADDR_EVENTS, 32'hf);
      end
      rd(`FTC_ADDR_STATUS, 32'h0, 32'h300);
      wr(`FTC_ADDR_CHLIST, 32'h1008);
      wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_FREQ, 5'h0, 1'b0));
      wait_irq();
      rd(`FTC_ADDR_STATUS, 32'h970, 32'hffff);
      for (int i = 0; i < 2; i++) rd(`FTC_ADDR_READING, 32'h800000be, 32'h80ffffff);
      rd(`FTC_ADDR_READING, 32'h0, 32'h80000000);
      src_run <= 1'b0;
      wr(`FTC_ADDR_EVENTS, 32'hf);
      lfsr = lfsr_next(lfsr);
      k = {28'h0, lfsr[3:0]} + 32'h3;
      // scan left its last channel closed; open all so only the totalize relay remains
      wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_OPEN, 5'h0, 1'b0));
      wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_TOTAL, 5'h05, 1'b1));
      src_run <= 1'b1;
      repeat (k * 10) @(posedge pclk);
      rd(`FTC_ADDR_TOTAL, k, 32'hffff);
      src_run <= 1'b0;
      repeat (6) @(posedge pclk);
      for (int i = 0; i < 2; i++) rd(`FTC_ADDR_TOTAL, k, 32'hffff);
      chk("relays", 32'h20, {2'h0, relay_close});
      rd(`FTC_ADDR_STATUS, 32'h3, 32'h7);
      src_run <= 1'b1;
      wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_TRIGGER, 5'h0, 1'b0));
      wait_irq();
      rd(`FTC_ADDR_READING, 32'h800000be, 32'h80ffffff);
      chk("relays", 32'h20, {2'h0, relay_close});
      src_run <= 1'b0;
      wr(`FTC_ADDR_EVENTS, 32'hf);
      wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_TOTAL, 5'h19, 1'b1));
      rd(`FTC_ADDR_EVENTS, 32'h2, 32'h2);
      rd(`FTC_ADDR_STATUS, 32'h0, 32'h7);
      wr(`FTC_ADDR_CMD, cmd(`FTC_CMD_OPEN, 5'h0, 1'b0));
      repeat (2) @(posedge pclk);
      chk("relays", 32'h0, {2'h0, relay_close});
      wr(`FTC_ADDR_MASK, 32'h2);
      repeat (2) @(posedge pclk);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      wr(`FTC_ADDR_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      conclude();
   end
endmodule : ftc_counter_tb_top
`default_nettype wire
